// File: src/bcl_pkg.sv
// constants shared by the band clock and low-voltage status block
package bcl_pkg;
    // ========================================================================
    // register byte addresses on the wishbone slave
    localparam logic [7:0] ADR_CTRL   = 8'h00;  // control and active configuration
    localparam logic [7:0] ADR_STATUS = 8'h04;  // status, flag clears on read
    localparam logic [7:0] ADR_CARR   = 8'h08;  // carrier frequency word
    localparam logic [7:0] ADR_DEV    = 8'h0C;  // deviation frequency word
    localparam logic [7:0] ADR_FREQA  = 8'h10;  // synthesizer word a
    localparam logic [7:0] ADR_FREQB  = 8'h14;  // synthesizer word b
    localparam logic [7:0] ADR_FREQC  = 8'h18;  // synthesizer word c
    localparam logic [7:0] ADR_CFG0   = 8'h1C;  // stored configuration set 0
    localparam logic [7:0] ADR_CFG1   = 8'h20;  // stored configuration set 1
    localparam logic [7:0] ADR_CLKINF = 8'h24;  // divide ratios in use
    // ========================================================================
    // control register fields
    localparam int CTL_LOW_VOLT_DETECT_ENABLE    = 0;   // low_volt_detect_enable
    localparam int CTL_RXEN    = 1;   // receive request
    localparam int CTL_DIRECT  = 2;   // direct frequency access method
    localparam int CTL_CFGSEL  = 3;   // configuration set chosen for load
    localparam int CTL_LOAD    = 4;   // write 1 loads chosen set, self clearing
    localparam int CTL_ACT_LSB = 8;   // active configuration byte lsb
    // active configuration byte layout
    localparam int CFG_BAND_LSB = 0;  // band_select, 2 bits
    localparam int CFG_LOF_LSB  = 2;  // lo_fine_select, 2 bits
    localparam int CFG_DME      = 4;  // data manager enable
    localparam int CFG_LNA_LSB  = 5;  // lna gain reduction step, 2 bits
    // status register fields
    localparam int STS_LVFLAG  = 0;   // latched low-voltage flag
    localparam int STS_UNLOCK  = 1;   // pll unlock input level
    localparam int STS_ST_LSB  = 2;   // control state, 2 bits
    // ========================================================================
    // reset values
    localparam logic [7:0]  CFG_RST  = 8'h00;
    localparam logic [15:0] FREQ_RST = 16'h0000;
    // ========================================================================
    // divide ratios of the reference clock
    localparam logic [6:0] DATA_DIV_LO = 7'h3C;  // 60
    localparam logic [6:0] DATA_DIV_HI = 7'h50;  // 80
    localparam logic [6:0] DIG_DIV_LO  = 7'h1E;  // 30
    localparam logic [6:0] DIG_DIV_HI  = 7'h28;  // 40
    localparam logic [3:0] IF_DIV_LO   = 4'h9;   // 9
    localparam logic [3:0] IF_DIV_HI   = 4'hC;   // 12
    // manchester half-bit length in data clock ticks
    localparam int MAN_HALF_DEF = 8;
    // ========================================================================
    // control state machine, gray along standby, receive, monitor
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_RECEIVE = 2'b01,
        ST_LVD     = 2'b11
    } bcl_state_t;
endpackage : bcl_pkg

// File: src/bcl_top.sv
// band clock planning, low-voltage status and receive data path
`timescale 1ns/100ps
module bcl_top
    import bcl_pkg::*;
#(
    parameter int MAN_HALF = MAN_HALF_DEF
)(
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        SUPPLY_LOW,
    input  wire logic        PLL_UNLOCK,
    input  wire logic        SLICED_DATA,
    input  wire logic        WAKEUP,
    output logic             LVD_DET_EN,
    output logic             STANDBY,
    output logic             DATA_CLK,
    output logic             DIG_CLK,
    output logic      [3:0]  IF_DIV,
    output logic      [1:0]  LNA_GAIN_RED,
    output logic      [1:0]  LO_FINE_SELECT,
    output logic             RX_DATA,
    output logic             RX_CLK,
    output logic      [15:0] FREQ_A,
    output logic      [15:0] FREQ_B,
    output logic      [15:0] FREQ_C
);
    // ========================================================================
    // ratio lookups
    function automatic logic [6:0] data_div(input logic b);
        data_div = b ? DATA_DIV_HI : DATA_DIV_LO;
    endfunction : data_div

    function automatic logic [6:0] dig_div(input logic b);
        dig_div = b ? DIG_DIV_HI : DIG_DIV_LO;
    endfunction : dig_div

    // ========================================================================
    // registers
    logic             low_volt_detect_enable_r, rxen_r, direct_r, cfgsel_r, lv_flag_r;
    logic [7:0]       act_r, cfg0_r, cfg1_r;
    logic [15:0]      carr_r, dev_r;
    logic             band_prev_r;
    logic [6:0]       dcnt_r, gcnt_r;
    bcl_state_t       state_r, state_nxt;
    logic             din_prev_r;
    logic [7:0]       tcnt_r;

    // ========================================================================
    // bus decode
    wire        acc        = CYC_I & STB_I & ~ACK_O;
    wire        wr         = acc & WE_I & SEL_I[0];
    wire        wr_hi      = acc & WE_I & SEL_I[1];
    wire        rd_status  = acc & ~WE_I & (ADR_I == ADR_STATUS);
    wire        band_low   = act_r[CFG_BAND_LSB];
    wire        band_chg   = band_low != band_prev_r;
    wire        lv_set     = low_volt_detect_enable_r & SUPPLY_LOW;
    wire        data_tick  = dcnt_r == data_div(band_low) - 7'h01;
    wire        dig_tick   = gcnt_r == dig_div(band_low) - 7'h01;
    wire        cfg_load   = (wr & (ADR_I == ADR_CTRL) & DAT_I[CTL_LOAD]) | WAKEUP;
    wire [7:0]  cfg_pick   = cfgsel_r ? cfg1_r : cfg0_r;
    wire        dme        = act_r[CFG_DME];
    wire        mid_edge   = (SLICED_DATA != din_prev_r) && (tcnt_r >= 8'(3 * MAN_HALF / 2));

    // read multiplexer, unmapped words read zero
    logic [31:0] rdata;
    always_comb
    begin
        rdata = 32'h0000_0000;
        case (ADR_I)
            ADR_CTRL:   rdata = {16'h0000, act_r, 3'h0, 1'b0, cfgsel_r, direct_r,
                                 rxen_r, low_volt_detect_enable_r};
            ADR_STATUS: rdata = {28'h0000000, state_r, PLL_UNLOCK, lv_flag_r};
            ADR_CARR:   rdata = {16'h0000, carr_r};
            ADR_DEV:    rdata = {16'h0000, dev_r};
            ADR_FREQA:  rdata = {16'h0000, FREQ_A};
            ADR_FREQB:  rdata = {16'h0000, FREQ_B};
            ADR_FREQC:  rdata = {16'h0000, FREQ_C};
            ADR_CFG0:   rdata = {24'h000000, cfg0_r};
            ADR_CFG1:   rdata = {24'h000000, cfg1_r};
            ADR_CLKINF: rdata = {13'h0000, IF_DIV, dig_div(band_low), 1'b0,
                                 data_div(band_low)};
            default:    rdata = 32'h0000_0000;
        endcase
    end

    // ========================================================================
    // wishbone answer: one wait state, ack drops the cycle after it rose
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end
        else
        begin
            ACK_O <= acc;
            DAT_O <= acc ? rdata : 32'h0000_0000;
        end
    end

    // control bits and configuration sets, all cleared by power-on reset
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            low_volt_detect_enable_r   <= 1'b0;
            rxen_r   <= 1'b0;
            direct_r <= 1'b0;
            cfgsel_r <= 1'b0;
            act_r    <= CFG_RST;
            cfg0_r   <= CFG_RST;
            cfg1_r   <= CFG_RST;
            carr_r   <= FREQ_RST;
            dev_r    <= FREQ_RST;
        end
        else
        begin
            if (wr && ADR_I == ADR_CTRL)
            begin
                low_volt_detect_enable_r   <= DAT_I[CTL_LOW_VOLT_DETECT_ENABLE];
                rxen_r   <= DAT_I[CTL_RXEN];
                direct_r <= DAT_I[CTL_DIRECT];
                cfgsel_r <= DAT_I[CTL_CFGSEL];
            end
            // a load beats a plain write of the active byte
            if (cfg_load)
                act_r <= cfg_pick;
            else if (wr_hi && ADR_I == ADR_CTRL)
                act_r <= DAT_I[CTL_ACT_LSB +: 8];
            if (wr && ADR_I == ADR_CFG0)
                cfg0_r <= DAT_I[7:0];
            if (wr && ADR_I == ADR_CFG1)
                cfg1_r <= DAT_I[7:0];
            if (wr && wr_hi && ADR_I == ADR_CARR)
                carr_r <= DAT_I[15:0];
            if (wr && wr_hi && ADR_I == ADR_DEV)
                dev_r <= DAT_I[15:0];
        end
    end

    // latched supply flag: a new low reading wins over the read that clears it
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
            lv_flag_r <= 1'b0;
        else if (lv_set)
            lv_flag_r <= 1'b1;
        else if (rd_status)
            lv_flag_r <= 1'b0;
    end

    // ========================================================================
    // synthesizer words: computed from carrier and deviation, or written
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            FREQ_A <= FREQ_RST;
            FREQ_B <= FREQ_RST;
            FREQ_C <= FREQ_RST;
        end
        else if (!direct_r)
        begin
            FREQ_A <= carr_r;
            FREQ_B <= 16'(carr_r + dev_r);
            FREQ_C <= 16'(carr_r - dev_r);
        end
        else if (wr && wr_hi)
        begin
            if (ADR_I == ADR_FREQA) FREQ_A <= DAT_I[15:0];
            if (ADR_I == ADR_FREQB) FREQ_B <= DAT_I[15:0];
            if (ADR_I == ADR_FREQC) FREQ_C <= DAT_I[15:0];
        end
    end

    // ========================================================================
    // dividers on the reference; the only clock is CORE_CLK itself
    // both restart at count zero when the band low bit moves
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            band_prev_r <= 1'b0;
            dcnt_r      <= 7'h00;
            gcnt_r      <= 7'h00;
            DATA_CLK    <= 1'b0;
            DIG_CLK     <= 1'b0;
        end
        else
        begin
            band_prev_r <= band_low;
            dcnt_r      <= (band_chg || data_tick) ? 7'h00 : dcnt_r + 7'h01;
            gcnt_r      <= (band_chg || dig_tick) ? 7'h00 : gcnt_r + 7'h01;
            // high while the next count lies in the first half, so even ratios give
            // exactly 50 percent; a restart or wrap lands on count zero, a high phase
            DATA_CLK    <= band_chg || data_tick ||
                           (dcnt_r + 7'h01 < (data_div(band_low) >> 1));
            DIG_CLK     <= band_chg || dig_tick ||
                           (gcnt_r + 7'h01 < (dig_div(band_low) >> 1));
        end
    end

    // static selections taken from the active configuration, detector enable from the control bit
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            IF_DIV         <= IF_DIV_LO;
            LNA_GAIN_RED   <= 2'h0;
            LO_FINE_SELECT <= 2'h0;
            LVD_DET_EN     <= 1'b0;
        end
        else
        begin
            IF_DIV         <= band_low ? IF_DIV_HI : IF_DIV_LO;
            LNA_GAIN_RED   <= act_r[CFG_LNA_LSB +: 2];
            LO_FINE_SELECT <= act_r[CFG_LOF_LSB +: 2];
            LVD_DET_EN     <= low_volt_detect_enable_r;
        end
    end

    // ========================================================================
    // control state machine, moves only on the digital clock tick
    always_comb
    begin
        case (state_r)
            ST_STANDBY, ST_RECEIVE, ST_LVD:
                state_nxt = rxen_r ? ST_RECEIVE : (low_volt_detect_enable_r ? ST_LVD : ST_STANDBY);
            default:
                state_nxt = ST_STANDBY;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_r <= ST_STANDBY;
            STANDBY <= 1'b1;
        end
        else if (dig_tick)
        begin
            state_r <= state_nxt;
            STANDBY <= state_nxt == ST_STANDBY;
        end
    end

    // ========================================================================
    // receive path: raw slicer output or manchester decode on data ticks
    // transitions closer than 3/4 bit to the last mid-bit edge are bit-boundary edges
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            din_prev_r <= 1'b0;
            tcnt_r     <= 8'hFF;
            RX_DATA    <= 1'b0;
            RX_CLK     <= 1'b0;
        end
        else if (state_r != ST_RECEIVE || PLL_UNLOCK)
        begin
            din_prev_r <= SLICED_DATA;
            tcnt_r     <= 8'hFF;
            RX_DATA    <= 1'b0;
            RX_CLK     <= 1'b0;
        end
        else if (!dme)
        begin
            RX_DATA <= SLICED_DATA;
            RX_CLK  <= 1'b0;
        end
        else if (data_tick)
        begin
            din_prev_r <= SLICED_DATA;
            if (mid_edge)
            begin
                tcnt_r  <= 8'h00;
                RX_DATA <= SLICED_DATA;
                RX_CLK  <= 1'b1;
            end
            else
            begin
                tcnt_r <= (tcnt_r == 8'hFF) ? tcnt_r : tcnt_r + 8'h01;
                if (tcnt_r == 8'(MAN_HALF))
                    RX_CLK <= 1'b0;
            end
        end
    end

    // ========================================================================
    // checks
    a_lvd_flag_set: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        low_volt_detect_enable_r && SUPPLY_LOW |=> lv_flag_r) else $error("supply low not flagged");
    a_lvd_flag_hold: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        lv_flag_r && !rd_status |=> lv_flag_r) else $error("flag lost without read");
    a_lvd_read_clr: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        rd_status && !lv_set |=> !lv_flag_r) else $error("read did not clear flag");
    a_no_standby_lvd: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        low_volt_detect_enable_r && dig_tick |=> state_r != ST_STANDBY && !STANDBY)
        else $error("standby entered with detector on");
    a_data_div_lo: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN || band_chg)
        data_tick && !band_low && $stable(act_r) |-> ##60 (data_tick || band_chg ||
        $past(band_chg))) else $error("data clock period not 60");
    a_dig_div_hi: assert property (@(posedge CORE_CLK)
        disable iff (!RSTN || band_chg)
        dig_tick && band_low && $stable(act_r) |-> ##1 (!dig_tick)[*8] ##32
        (dig_tick || band_chg || $past(band_chg))) else $error("digital clock period not 40");
    a_if_divisor: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        1'b1 |=> IF_DIV == ($past(band_low) ? 4'hC : 4'h9)) else $error("wrong if divisor");
    a_unlock_gate: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        PLL_UNLOCK |=> !RX_DATA && !RX_CLK) else $error("data passed while unlocked");
    a_raw_pass: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        state_r == ST_RECEIVE && !dme && !PLL_UNLOCK |=> RX_DATA == $past(SLICED_DATA))
        else $error("raw data not passed");
    a_cfg_load: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        WAKEUP |=> act_r == $past(cfg_pick)) else $error("configuration not loaded");
    a_freq_calc: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        !direct_r |=> FREQ_B == 16'($past(carr_r) + $past(dev_r)))
        else $error("computed word wrong");
    a_wb_ack: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        acc |=> ACK_O ##1 !ACK_O) else $error("ack not one cycle");
endmodule : bcl_top

// File: tb/bcl_top_tb.sv
// self-checking bench for the band clock and low-voltage status block
`timescale 1ns/100ps
module bcl_top_tb;
    import bcl_pkg::*;
    // ========================================================================
    // bench signals
    logic        clk, rstn, cyc, stb, we, sup_low, unlock, sliced, wake;
    logic [7:0]  adr, c0, c1;
    logic [3:0]  sel, if_div;
    logic [31:0] dat_i, dat_o, q;
    logic        ack, lvd_en, stby, data_clk, dig_clk, rx_data, rx_clk, prev, mbit;
    logic [1:0]  lna, lo_fine_select;
    logic [15:0] fa, fb, fc, carr, dev;
    int          fails, comparisons, per, hi;

    // short manchester half bit keeps receive runs brief
    bcl_top #(.MAN_HALF(2)) bcl_top_i (
        .CORE_CLK(clk), .RSTN(rstn), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack),
        .SUPPLY_LOW(sup_low), .PLL_UNLOCK(unlock), .SLICED_DATA(sliced),
        .WAKEUP(wake), .LVD_DET_EN(lvd_en), .STANDBY(stby), .DATA_CLK(data_clk),
        .DIG_CLK(dig_clk), .IF_DIV(if_div), .LNA_GAIN_RED(lna),
        .LO_FINE_SELECT(lo_fine_select), .RX_DATA(rx_data), .RX_CLK(rx_clk),
        .FREQ_A(fa), .FREQ_B(fb), .FREQ_C(fc));

    // 100 MHz reference
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ========================================================================
    // expectations and bus tasks
    function automatic logic [31:0] exp_clkinf(input logic b);
        exp_clkinf = b ? {13'h0, IF_DIV_HI, DIG_DIV_HI, 1'b0, DATA_DIV_HI}
                       : {13'h0, IF_DIV_LO, DIG_DIV_LO, 1'b0, DATA_DIV_LO};
    endfunction : exp_clkinf

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // classic cycle: hold until ack is sampled, then release for one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat_i <= d;
        // no cycle count assumed: only the watchdog ends a hung wait
        do
        begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask : wb

    // period and high time of a divided clock, in reference cycles
    task automatic meas(input logic dg, output int p, output int h);
        logic c, l;
        int   st;
        st = 0; p = 0; h = 0; l = 1'b1;
        repeat (400)
        begin
            @(posedge clk);
            c = dg ? dig_clk : data_clk;
            if (c === 1'b1 && l === 1'b0) st++;
            if (st == 1)
            begin
                p++;
                if (c === 1'b1) h++;
            end
            l = c;
        end
    endtask : meas

    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // a hang counts as a mismatch and ends through the same closing task
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        wrap_up();
    end

    // ========================================================================
    // main sequence
    initial
    begin
        {rstn, cyc, stb, we, sup_low, unlock, sliced, wake} = '0;
        adr = '0; sel = '0; dat_i = '0; fails = 0; comparisons = 0; prev = 1'b0;
        void'($urandom(94341));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("standby", {31'h0, stby}, 32'h1);
        chk("if_div", {28'h0, if_div}, 32'h9);
        for (int i = 0; i < 9; i++)
        begin
            wb(1'b0, 8'(4 * i), 4'hF, 32'h0);
            chk("reset reg", q, 32'h0);
        end
        $display("test reset done");
        // dividers for both band low bit values
        for (int b = 0; b < 2; b++)
        begin
            wb(1'b1, ADR_CTRL, 4'h2, 32'(b) << 8);
            meas(1'b0, per, hi);
            chk("data period", per, b ? 80 : 60);
            chk("data high", hi, b ? 40 : 30);
            meas(1'b1, per, hi);
            chk("dig period", per, b ? 40 : 30);
            chk("dig high", hi, b ? 20 : 15);
            chk("if_div", {28'h0, if_div}, b ? 32'hC : 32'h9);
            wb(1'b0, ADR_CLKINF, 4'hF, 32'h0);
            chk("clkinfo", q, exp_clkinf(b[0]));
        end
        $display("test clocks done");
        // supply dip with detect disabled, then enabled
        sup_low <= 1'b1;
        @(posedge clk);
        sup_low <= 1'b0;
        wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
        chk("flag off", q, 32'h0);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h1);
        repeat (100) @(posedge clk);
        chk("det en", {31'h0, lvd_en}, 32'h1);
        chk("no standby", {31'h0, stby}, 32'h0);
        sup_low <= 1'b1;
        @(posedge clk);
        sup_low <= 1'b0;
        wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
        chk("flag set", q, 32'hD);
        wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
        chk("flag clear", q, 32'hC);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h0);
        repeat (100) @(posedge clk);
        chk("standby", {31'h0, stby}, 32'h1);
        $display("test lvd done");
        // computed words, ignored direct write, then direct access
        carr = 16'($urandom);
        dev = 16'($urandom);
        wb(1'b1, ADR_CARR, 4'hF, {16'h0, carr});
        wb(1'b1, ADR_DEV, 4'hF, {16'h0, dev});
        wb(1'b1, ADR_FREQA, 4'hF, {16'h0, ~carr});
        repeat (3) @(posedge clk);
        chk("freq a", {16'h0, fa}, {16'h0, carr});
        chk("freq b", {16'h0, fb}, {16'h0, 16'(carr + dev)});
        chk("freq c", {16'h0, fc}, {16'h0, 16'(carr - dev)});
        wb(1'b1, ADR_CTRL, 4'h1, 32'h4);
        for (int i = 0; i < 3; i++)
            wb(1'b1, 8'(ADR_FREQA + 4 * i), 4'hF, {16'h0, 16'(~carr + i)});
        repeat (3) @(posedge clk);
        chk("direct a", {16'h0, fa}, {16'h0, ~carr});
        chk("direct b", {16'h0, fb}, {16'h0, 16'(~carr + 1)});
        chk("direct c", {16'h0, fc}, {16'h0, 16'(~carr + 2)});
        wb(1'b1, ADR_CTRL, 4'h1, 32'h0);
        $display("test freq done");
        // stored sets: software load of set 1, wakeup load of set 0
        c0 = 8'($urandom) & 8'h6F;
        c1 = 8'($urandom) & 8'h6F;
        wb(1'b1, ADR_CFG0, 4'hF, {24'h0, c0});
        wb(1'b1, ADR_CFG1, 4'hF, {24'h0, c1});
        wb(1'b1, ADR_CTRL, 4'h1, 32'h08);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h18);
        wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
        chk("load set1", q, {16'h0, c1, 8'h08});
        chk("lna", {30'h0, lna}, {30'h0, c1[6:5]});
        chk("lo fine", {30'h0, lo_fine_select}, {30'h0, c1[3:2]});
        wb(1'b1, ADR_CTRL, 4'h1, 32'h0);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (2) @(posedge clk);
        wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
        chk("wake set0", q, {16'h0, c0, 8'h00});
        for (int k = 0; k < 4; k++)
        begin
            wb(1'b1, ADR_CTRL, 4'h2, 32'(k) << 13);
            repeat (2) @(posedge clk);
            chk("lna step", {30'h0, lna}, 32'(k));
        end
        $display("test config done");
        // raw receive path, then loss of lock
        wb(1'b1, ADR_CTRL, 4'h3, 32'h2);
        repeat (100) @(posedge clk);
        wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
        chk("receive st", q, 32'h4);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk);
            prev = sliced;
            sliced <= 1'($urandom);
            #1;
            chk("rx data", {31'h0, rx_data}, {31'h0, prev});
            chk("rx clk", {31'h0, rx_clk}, 32'h0);
        end
        @(posedge clk);
        unlock <= 1'b1;
        sliced <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("unlocked rx", {31'h0, rx_data}, 32'h0);
        @(posedge clk);
        wb(1'b0, ADR_STATUS, 4'hF, 32'h0);
        chk("unlock st", q, 32'h6);
        unlock <= 1'b0;
        // data manager on: two data ticks per half bit, a leading 0 gives the first mid edge
        wb(1'b1, ADR_CTRL, 4'h2, 32'h1000);
        for (int i = 0; i < 4; i++)
        begin
            mbit = (i == 0) ? 1'b0 : 1'($urandom);
            sliced <= ~mbit;
            repeat (2 * DATA_DIV_LO) @(posedge clk);
            sliced <= mbit;
            repeat (2 * DATA_DIV_LO) @(posedge clk);
            chk("man data", {31'h0, rx_data}, {31'h0, mbit});
            chk("man clk", {31'h0, rx_clk}, 32'h1);
        end
        $display("test receive done");
        // unmapped place reads zero and ignores writes
        wb(1'b1, 8'hFC, 4'hF, 32'hFFFF_FFFF);
        wb(1'b0, 8'hFC, 4'hF, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b0, ADR_CTRL, 4'hF, 32'h0);
        chk("ctrl kept", q, 32'h1002);
        $display("test unmapped done");
        wrap_up();
    end
endmodule : bcl_top_tb
